// ==== rtl/freq_period_meter.sv ====
`include "freq_meter_map.svh"
`default_nettype none
module freq_period_meter (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // configuration
    input  wire logic [2:0]  INPUT_USE,
    input  wire logic [1:0]  GATE_TIME,
    // measurement input
    input  wire logic        MEAS_IN,
    // result
    output logic [7:0]       RESULT_B0,
    output logic [7:0]       RESULT_B1,
    output logic [7:0]       RESULT_B2,
    output logic             RESULT_VALID,
    output logic             RESULT_STROBE
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        freq_meter_pkg::meas_state_e    state;
        logic                           in_d;
        logic [2:0]                     use_d;
        logic [1:0]                     gate_d;
        logic [24:0]                    gate_cnt;
        freq_meter_pkg::result_t        acc;
        freq_meter_pkg::result_t        result;
        logic                           valid;
        logic                           strobe;
    } meter_s;

    meter_s                      st_r;
    meter_s                      st_nxt;
    logic                        tick;
    logic                        rise;
    logic                        tick_restart;
    logic                        cfg_change;
    logic                        period_mode;
    logic                        gate_end;
    logic                        acc_full;
    logic [23:0]                 acc_inc;
    logic [23:0]                 period_count;
    logic [24:0]                 gate_len;
    freq_meter_pkg::meas_state_e start_state;
    freq_meter_pkg::result_t     start_result;

    // ------------------------------------------------------------------------
    // half microsecond time base
    // ------------------------------------------------------------------------
    tick_gen #(
        .CYCLES (`TICK_CYCLES)
    ) u_tick (
        .clk     (CLK),
        .srst    (SRST),
        .restart (tick_restart),
        .tick    (tick)
    );

    // ------------------------------------------------------------------------
    // input edge and configuration decode
    // ------------------------------------------------------------------------
    // a mode starts only after idle has refreshed the previous sample, so reset leaves no false edge
    assign rise = MEAS_IN & ~st_r.in_d;
    // a change of use or gate restarts the measurement from scratch
    assign cfg_change = (INPUT_USE != st_r.use_d) || (GATE_TIME != st_r.gate_d);
    assign period_mode = (st_r.state == freq_meter_pkg::ST_WAIT_EDGE)
        || (st_r.state == freq_meter_pkg::ST_PERIOD);
    // realign the time base at every period edge so ticks are counted from the edge
    assign tick_restart = period_mode && rise;

    // ------------------------------------------------------------------------
    // gate length in ticks
    // ------------------------------------------------------------------------
    always_comb begin
        case (st_r.gate_d)
            `GATE_100MS: gate_len = 25'(`GATE_100MS_TICKS);
            `GATE_1S:    gate_len = 25'(`GATE_1S_TICKS);
            `GATE_10S:   gate_len = 25'(`GATE_10S_TICKS);
            default:     gate_len = 25'(`GATE_1S_TICKS);
        endcase
    end

    // the last tick of the gate closes it
    assign gate_end = tick && (st_r.gate_cnt == gate_len - 25'h000_0001);

    // ------------------------------------------------------------------------
    // accumulator helpers
    // ------------------------------------------------------------------------
    assign acc_full = (st_r.acc == `RESULT_ALL_ONES);
    // the count holds at all ones instead of wrapping
    assign acc_inc = acc_full ? st_r.acc : st_r.acc + 24'h00_0001;
    // a tick that lands on the closing edge still belongs to the period just ended
    assign period_count = tick ? acc_inc : st_r.acc;

    // ------------------------------------------------------------------------
    // values a mode starts from
    // ------------------------------------------------------------------------
    always_comb begin
        case (st_r.use_d)
            `USE_EDGE_RATE: begin
                start_state  = freq_meter_pkg::ST_FREQ;
                start_result = `FREQ_INVALID;
            end
            `USE_PERIOD: begin
                start_state  = freq_meter_pkg::ST_WAIT_EDGE;
                start_result = 24'h00_0000;
            end
            default: begin
                // other uses leave the block idle with a zero result
                start_state  = freq_meter_pkg::ST_IDLE;
                start_result = 24'h00_0000;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    // idle waits one cycle with the new configuration; frequency mode counts edges per gate;
    // period mode first waits for an edge, then counts ticks from edge to edge
    always_comb begin
        st_nxt = st_r;
        st_nxt.in_d = MEAS_IN;
        st_nxt.use_d = INPUT_USE;
        st_nxt.gate_d = GATE_TIME;
        st_nxt.strobe = 1'b0;
        if (cfg_change) begin
            st_nxt.state = freq_meter_pkg::ST_IDLE;
        end else begin
            case (st_r.state)
                freq_meter_pkg::ST_IDLE: begin
                    st_nxt.gate_cnt = 25'h000_0000;
                    st_nxt.acc = 24'h00_0000;
                    st_nxt.valid = 1'b0;
                    st_nxt.state = start_state;
                    st_nxt.result = start_result;
                end
                freq_meter_pkg::ST_FREQ: begin
                    if (gate_end) begin
                        // latch and restart in the same cycle; a coincident edge opens the new gate
                        st_nxt.result = st_r.acc;
                        st_nxt.acc = rise ? 24'h00_0001 : 24'h00_0000;
                        st_nxt.gate_cnt = 25'h000_0000;
                        st_nxt.valid = 1'b1;
                        st_nxt.strobe = 1'b1;
                    end else begin
                        if (tick) begin
                            st_nxt.gate_cnt = st_r.gate_cnt + 25'h000_0001;
                        end
                        if (rise) begin
                            st_nxt.acc = acc_inc;
                        end
                    end
                end
                freq_meter_pkg::ST_WAIT_EDGE: begin
                    if (rise) begin
                        st_nxt.acc = 24'h00_0000;
                        st_nxt.state = freq_meter_pkg::ST_PERIOD;
                    end
                end
                freq_meter_pkg::ST_PERIOD: begin
                    if (rise) begin
                        st_nxt.result = period_count;
                        st_nxt.acc = 24'h00_0000;
                        st_nxt.valid = 1'b1;
                        st_nxt.strobe = 1'b1;
                    end else if (tick) begin
                        st_nxt.acc = acc_inc;
                    end
                    // saturated count stands as result; no other indication exists
                    if (acc_full && st_r.result != `RESULT_ALL_ONES) begin
                        st_nxt.result = `RESULT_ALL_ONES;
                        st_nxt.valid = 1'b1;
                        st_nxt.strobe = 1'b1;
                    end
                end
                default: begin
                    st_nxt.state = freq_meter_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign RESULT_B0 = st_r.result[7:0];
    assign RESULT_B1 = st_r.result[15:8];
    assign RESULT_B2 = st_r.result[23:16];
    assign RESULT_VALID = st_r.valid;
    assign RESULT_STROBE = st_r.strobe;
endmodule // freq_period_meter
`default_nettype wire

// ==== rtl/freq_meter_map.svh ====
`ifndef FREQ_METER_MAP_SVH
`define FREQ_METER_MAP_SVH
// ----------------------------------------------------------------------------
// input use codes
// ----------------------------------------------------------------------------
`define USE_EDGE_RATE       3'h3
`define USE_PERIOD          3'h4
// ----------------------------------------------------------------------------
// gate time codes
// ----------------------------------------------------------------------------
`define GATE_100MS          2'h0
`define GATE_1S             2'h1
`define GATE_10S            2'h2
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_PS       5000
`define TICK_INTERVAL_PS    500000
`define TICK_CYCLES         (`TICK_INTERVAL_PS / `CLK_PERIOD_PS)
`define GATE_100MS_TICKS    200000
`define GATE_1S_TICKS       2000000
`define GATE_10S_TICKS      20000000
// ----------------------------------------------------------------------------
// result values
// ----------------------------------------------------------------------------
`define RESULT_ALL_ONES     24'hFF_FFFF
`define FREQ_INVALID        24'h0F_FFFF
`endif

// ==== rtl/freq_meter_pkg.sv ====
`default_nettype none
package freq_meter_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FREQ,
        ST_WAIT_EDGE,
        ST_PERIOD
    } meas_state_e;
    typedef logic [23:0] result_t;
endpackage
`default_nettype wire

// ==== rtl/tick_gen.sv ====
`include "freq_meter_map.svh"
`default_nettype none
module tick_gen #(
    parameter int unsigned CYCLES = 100
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic restart,
    output logic      tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tick_s;
    tick_s st_r;
    tick_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (restart) begin
            // the restart cycle is already the first cycle of the new interval
            st_nxt.cnt = 8'h01;
        end else if (st_r.cnt == 8'(CYCLES - 1)) begin
            st_nxt.cnt = 8'h00;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule // tick_gen
`default_nettype wire

// ==== verif/freq_period_meter_assertions.sv ====
`include "freq_meter_map.svh"
`default_nettype none
module freq_period_meter_assertions (
    // clock and reset
    input wire logic       CLK,
    input wire logic       SRST,
    // configuration and input
    input wire logic [2:0] INPUT_USE,
    input wire logic [1:0] GATE_TIME,
    input wire logic       MEAS_IN,
    // result
    input wire logic [7:0] RESULT_B0,
    input wire logic [7:0] RESULT_B1,
    input wire logic [7:0] RESULT_B2,
    input wire logic       RESULT_VALID,
    input wire logic       RESULT_STROBE
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        meas_q_r;
    logic        rise;
    logic [23:0] res;
    assign res  = {RESULT_B2, RESULT_B1, RESULT_B0};
    assign rise = MEAS_IN && !meas_q_r;
    always_ff @(posedge CLK) meas_q_r <= MEAS_IN;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_strobe_single: assert property (RESULT_STROBE |=> !RESULT_STROBE) else $error("strobe too long");
    a_strobe_valid: assert property (RESULT_STROBE |-> RESULT_VALID) else $error("strobe without valid");
    a_reset_zero: assert property ($fell(SRST) |-> res == 24'h00_0000 && !RESULT_VALID) else $error("reset");
    a_idle_zero: assert property ((INPUT_USE != `USE_EDGE_RATE && INPUT_USE != `USE_PERIOD)[*3]
        |-> res == 24'h00_0000 && !RESULT_VALID) else $error("idle result not zero");
    a_freq_marker: assert property ((INPUT_USE == `USE_EDGE_RATE)[*5] ##0 !RESULT_VALID
        |-> res == `FREQ_INVALID) else $error("frequency marker missing");
    a_rise_strobe: assert property (INPUT_USE == `USE_PERIOD && $stable(INPUT_USE) && RESULT_VALID && rise
        |-> ##[1:3] RESULT_STROBE) else $error("period edge gave no result");
    a_strobe_after_rise: assert property (RESULT_STROBE && INPUT_USE == `USE_PERIOD && res != `RESULT_ALL_ONES
        |-> $past(rise) || $past(rise, 2) || $past(rise, 3)) else $error("period result without edge");
    a_bytes_together: assert property ($changed(res) && RESULT_VALID && $past(RESULT_VALID)
        |-> RESULT_STROBE) else $error("result changed without strobe");
endmodule // freq_period_meter_assertions
bind freq_period_meter freq_period_meter_assertions u_chk (.CLK(CLK), .SRST(SRST), .INPUT_USE(INPUT_USE),
    .GATE_TIME(GATE_TIME), .MEAS_IN(MEAS_IN), .RESULT_B0(RESULT_B0), .RESULT_B1(RESULT_B1),
    .RESULT_B2(RESULT_B2), .RESULT_VALID(RESULT_VALID), .RESULT_STROBE(RESULT_STROBE));
`default_nettype wire

// ==== verif/pulse_source.sv ====
`default_nettype none
module pulse_source (
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic [31:0] period_cyc,
    output var  logic        meas
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned cnt = 1000;
    int unsigned per = 0;
    initial meas = 1'b0;
    // one rising edge every period_cyc clocks, low while disabled
    always @(posedge clk) begin
        #1;
        if (!en) begin
            cnt  = 1000;
            meas = 1'b0;
        end else if (cnt == 0) begin
            per  = period_cyc;
            cnt  = per - 1;
            meas = 1'b1;
        end else begin
            cnt--;
            if (cnt == per / 2) meas = 1'b0;
        end
    end
endmodule // pulse_source
`default_nettype wire

// ==== verif/freq_period_meter_tb_top.sv ====
`include "freq_meter_map.svh"
`default_nettype none
module freq_period_meter_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, srst = 1'b1, src_en = 1'b0, prev_m = 1'b0, started = 1'b0;
    logic        meas, valid, strobe;
    logic [2:0]  input_use = `USE_EDGE_RATE;
    logic [1:0]  gate_time = `GATE_100MS;
    logic [7:0]  b0, b1, b2;
    logic [31:0] next_per = 32'h0000_4E52;
    int          errors = 0, checks = 0, seed = 68, cyc = 0, last = 0, seen = 0;
    int          expq[$];
    always #2.5 clk = ~clk;
    freq_period_meter uut (.CLK(clk), .SRST(srst), .INPUT_USE(input_use), .GATE_TIME(gate_time), .MEAS_IN(meas),
        .RESULT_B0(b0), .RESULT_B1(b1), .RESULT_B2(b2), .RESULT_VALID(valid), .RESULT_STROBE(strobe));
    pulse_source src (.clk(clk), .en(src_en), .period_cyc(next_per), .meas(meas));
    task automatic check(input string name, input logic [23:0] seen_v, input logic [23:0] exp_v);
        checks++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // reference model of period mode, sampled mid-cycle
    // ------------------------------------------------------------------------
    always @(negedge clk) begin
        cyc++;
        if (src_en && meas && !prev_m) begin
            if (started) expq.push_back((cyc - last) / 100);
            started  = 1'b1;
            last     = cyc;
            next_per = 32'((200 + $unsigned($random(seed)) % 21) * 100 + $unsigned($random(seed)) % 100);
        end
        prev_m = meas;
        if (strobe && src_en) begin
            check("period result", {b2, b1, b0}, expq.size() > 0 ? 24'(expq.pop_front()) : 24'hxx_xxxx);
            check("period valid", 24'(valid), 24'h00_0001);
            seen++;
        end
        if (cyc == 90000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;
        repeat (20) @(posedge clk);
        #1 check("freq marker", {b2, b1, b0}, `FREQ_INVALID);
        check("freq valid", 24'(valid), 24'h00_0000);
        for (int g = 0; g < 4; g++) begin
            gate_time = 2'(g);
            repeat (10) @(posedge clk);
            #1 check("gate marker", {b2, b1, b0}, `FREQ_INVALID);
        end
        $display("test frequency start done");
        input_use = 3'h0;
        repeat (5) @(posedge clk);
        #1 check("idle result", {b2, b1, b0}, 24'h00_0000);
        check("idle valid", 24'(valid), 24'h00_0000);
        $display("test idle done");
        input_use = `USE_PERIOD;
        repeat (5) @(posedge clk);
        #1 src_en = 1'b1;
        while (seen < 3) @(posedge clk);
        $display("test period done");
        complete_run();
    end
endmodule // freq_period_meter_tb_top
`default_nettype wire
